/* File: cpr_codec_regs.sv */
// cpr_codec_regs.sv: programmable registers of a pcm codec, with the
// serial control port, power state, latches and pcm output gating.
// assumes: every input is synchronous to ref_clk; control clock and
// bit clock are sampled levels, far slower than ref_clk.
`include "cpr_consts.svh"
module cpr_codec_regs #(
  parameter cpr_pkg::cpr_ctrl_t CTRL_RESET = `CPR_CTRL_RESET,
  parameter int LATCHES = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial control port
  input wire logic control_clock,
  input wire logic control_in,
  input wire logic cs_n,
  output logic control_out,
  output logic control_out_oe,
  // pcm interface
  input wire logic bclk,
  input wire logic tx_frame_sync,
  input wire logic rx_frame_sync,
  input wire logic pcm_rx_in,
  input wire logic [7:0] enc_code,
  output logic pcm_tx_out,
  output logic pcm_tx_oe,
  output logic [7:0] dec_code,
  // interface latches
  input wire logic [LATCHES-1:0] latch_pin_in,
  output logic [LATCHES-1:0] latch_pin_out,
  output logic [LATCHES-1:0] latch_pin_oe,
  // mode outputs
  output cpr_pkg::cpr_ctrl_t ctrl_fields,
  output logic sleep_state,
  output logic amp_enable,
  output logic analog_tx_from_rx,
  output logic digital_loop_on
);
  import cpr_pkg::*;

  cpr_port_state_t state;
  logic control_clock_q;
  logic bclk_q;
  logic control_clock_fall;
  logic control_clock_rise;
  logic bclk_rise;
  logic bclk_fall;
  logic [2:0] bit_cnt;
  logic [7:0] in_sr;
  logic [7:0] next_sr;
  logic [7:0] out_sr;
  logic [3:0] addr;
  logic rd;
  logic byte_done;
  logic b1_done;
  logic b2_done;
  logic wr_ctrl;
  logic wr_ldir;
  logic wr_ldata;
  logic rd_load;
  logic [7:0] latch_direction;
  logic [7:0] latch_data;
  logic [7:0] latch_read;
  logic [7:0] rd_mux;
  logic [1:0] fs_q;
  logic [1:0] fs_edge;
  logic [1:0] pend;
  logic [1:0] late;
  logic [1:0] slot_start;
  logic [1:0] wake_cnt;
  logic tx_allowed;
  logic tx_busy;

  // edge pulses of the sampled control and bit clocks
  assign control_clock_fall = control_clock_q && !control_clock;
  assign control_clock_rise = !control_clock_q && control_clock;
  assign bclk_rise = !bclk_q && bclk;
  assign bclk_fall = bclk_q && !bclk;

  // instruction decode
  assign next_sr = {in_sr[6:0], control_in};
  assign byte_done = control_clock_fall && !cs_n && (bit_cnt == `CPR_BIT_LAST);
  assign b1_done = byte_done && (state == CPR_ST_BYTE1);
  assign b2_done = byte_done && (state == CPR_ST_BYTE2) && !rd;
  assign wr_ctrl = b2_done && (addr == `CPR_ADDR_CTRL);
  assign wr_ldata = b2_done && (addr == `CPR_ADDR_LDATA);
  assign wr_ldir = b2_done && (addr == `CPR_ADDR_LDIR);
  assign rd_load = b1_done && next_sr[`CPR_B1_TWO_BYTE]
    && next_sr[`CPR_B1_READ];

  // read data selection; unknown addresses read as zero
  assign rd_mux =
    (next_sr[`CPR_B1_ADDR_HI:`CPR_B1_ADDR_LO] == `CPR_ADDR_CTRL) ?
      ctrl_fields :
    (next_sr[`CPR_B1_ADDR_HI:`CPR_B1_ADDR_LO] == `CPR_ADDR_LDATA) ?
      latch_read :
    (next_sr[`CPR_B1_ADDR_HI:`CPR_B1_ADDR_LO] == `CPR_ADDR_LDIR) ?
      latch_direction : 8'h00;

  // clock edge history
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      control_clock_q <= 1'b0;
      bclk_q <= 1'b0;
    end else begin
      control_clock_q <= control_clock;
      bclk_q <= bclk;
    end
  end

  // control port bit and byte sequencing; power bit taken from byte 1
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= CPR_ST_BYTE1;
      bit_cnt <= 3'h0;
      in_sr <= 8'h00;
      addr <= 4'h0;
      rd <= 1'b0;
      sleep_state <= `CPR_SLEEP_RESET;
    end else if (cs_n) begin
      bit_cnt <= 3'h0;
      state <= CPR_ST_BYTE1;
    end else if (control_clock_fall) begin
      bit_cnt <= bit_cnt + 3'h1;
      in_sr <= next_sr;
      if (byte_done) begin
        case (state)
          CPR_ST_BYTE1: begin
            sleep_state <= next_sr[`CPR_B1_POWER];
            if (next_sr[`CPR_B1_TWO_BYTE]) begin
              addr <= next_sr[`CPR_B1_ADDR_HI:`CPR_B1_ADDR_LO];
              rd <= next_sr[`CPR_B1_READ];
              state <= CPR_ST_BYTE2;
            end
          end
          CPR_ST_BYTE2: begin
            state <= CPR_ST_BYTE1;
          end
          default: begin
            state <= CPR_ST_BYTE1;
          end
        endcase
      end
    end
  end

  // register writes; only reset restores power-on values
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_fields <= CTRL_RESET;
      latch_direction <= `CPR_LDIR_RESET;
      latch_data <= `CPR_LDATA_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_fields <= next_sr;
      end
      if (wr_ldir) begin
        latch_direction <= next_sr;
      end
      if (wr_ldata) begin
        latch_data <= next_sr;
      end
    end
  end

  // read-back: loaded after byte 1, shifted out on rising edges
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_sr <= 8'h00;
      control_out <= 1'b0;
    end else if (rd_load) begin
      out_sr <= rd_mux;
    end else if (control_clock_rise && control_out_oe) begin
      control_out <= out_sr[7];
      out_sr <= {out_sr[6:0], 1'b0};
    end
  end
  assign control_out_oe = !cs_n && (state == CPR_ST_BYTE2) && rd;

  // latch pins; data bits 2 and 3 have no pin and read back as written
  assign latch_read[7-LATCHES:2] = latch_data[7-LATCHES:2];
  assign latch_read[1:0] = 2'b00;
  genvar gi;
  generate
    for (gi = 0; gi < LATCHES; gi = gi + 1) begin : g_latch
      assign latch_pin_oe[gi] = latch_direction[`CPR_LATCH_TOP-gi];
      assign latch_pin_out[gi] = latch_data[`CPR_LATCH_TOP-gi];
      assign latch_read[`CPR_LATCH_TOP-gi] =
        latch_direction[`CPR_LATCH_TOP-gi] ?
          latch_data[`CPR_LATCH_TOP-gi] : latch_pin_in[gi];
    end
  endgenerate

  // loop and amplifier controls
  assign digital_loop_on = ctrl_fields.digital_loop_sel;
  assign analog_tx_from_rx = !ctrl_fields.digital_loop_sel
    && ctrl_fields.analog_loop_sel;
  assign amp_enable = !(sleep_state
    && ctrl_fields.amp_off_in_sleep);

  // slot starts: non-delayed at the sync edge, delayed one bit later
  assign slot_start = {2{bclk_rise}} & (pend | fs_edge)
    & ({2{ctrl_fields.timing_sel}} | late);
  assign fs_edge = {rx_frame_sync, tx_frame_sync} & ~fs_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fs_q <= 2'b00;
      pend <= 2'b00;
      late <= 2'b00;
    end else begin
      fs_q <= {rx_frame_sync, tx_frame_sync};
      for (int c = 0; c < 2; c++) begin
        if (slot_start[c]) begin
          pend[c] <= 1'b0;
          late[c] <= 1'b0;
        end else if (fs_edge[c]) begin
          pend[c] <= 1'b1;
          late[c] <= bclk_rise;
        end else if (bclk_rise && pend[c]) begin
          late[c] <= 1'b1;
        end
      end
    end
  end

  // transmit frames counted after power-up before output may drive
  always_ff @(posedge ref_clk) begin
    if (rst || sleep_state) begin
      wake_cnt <= 2'h0;
    end else if (fs_edge[0] && !tx_allowed) begin
      wake_cnt <= wake_cnt + 2'h1;
    end
  end
  assign tx_allowed = !sleep_state && (wake_cnt == `CPR_TX_WAKE_FRAMES);
  assign pcm_tx_oe = tx_allowed && tx_busy;

  cpr_pcm_shift u_shift (
    .ref_clk(ref_clk),
    .rst(rst),
    .bclk_rise(bclk_rise),
    .bclk_fall(bclk_fall),
    .tx_start(slot_start[0]),
    .rx_start(slot_start[1]),
    .even_invert(ctrl_fields.law_sel && !ctrl_fields.inversion_off),
    .digital_loop(ctrl_fields.digital_loop_sel),
    .enc_code(enc_code),
    .pcm_rx_in(pcm_rx_in),
    .pcm_tx_out(pcm_tx_out),
    .tx_busy(tx_busy),
    .dec_code(dec_code)
  );

  // assertions share the reference clock and stand down in reset
  default clocking regs_cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_read_first_bit;
    control_clock_rise && control_out_oe;
  endsequence

  a_power_bit: assert property (
    b1_done |=> sleep_state == $past(next_sr[7]))
    else $error("power bit not applied");

  a_ctrl_load: assert property (
    wr_ctrl |=> ctrl_fields == $past(next_sr))
    else $error("control register not loaded");

  a_ctrl_hold: assert property (
    !wr_ctrl |=> $stable(ctrl_fields))
    else $error("control register changed without write");

  a_abort_reset: assert property (
    cs_n |=> bit_cnt == 3'h0 && state == CPR_ST_BYTE1 && !b2_done)
    else $error("counters not reset on chip select");

  a_tx_quiet_wake: assert property (
    $fell(sleep_state) |-> !pcm_tx_oe [*2])
    else $error("pcm output driven too soon after power-up");

  a_read_msb: assert property (
    rd_load ##[1:8] s_read_first_bit |=> control_out == $past(out_sr[7]))
    else $error("read-back first bit wrong");

  a_latch_read: assert property (
    rd_load && next_sr[6:3] == 4'h1 |=> out_sr[7] ==
      $past(latch_direction[7] ? latch_data[7] : latch_pin_in[0]))
    else $error("latch read-back wrong");

  a_latch_dir: assert property (
    wr_ldir |=> latch_pin_oe[0] == $past(next_sr[7])
      && latch_pin_oe[3] == $past(next_sr[4]))
    else $error("latch direction not applied");

  a_analog_loop: assert property (
    wr_ctrl && next_sr[2:1] == 2'b01 |=> analog_tx_from_rx)
    else $error("analog loop not entered");

  a_amp_sleep: assert property (
    b1_done && next_sr[7] && ctrl_fields.amp_off_in_sleep
      && !wr_ctrl |=> !amp_enable)
    else $error("amplifier not disabled in power-down");

endmodule : cpr_codec_regs

/* File: cpr_consts.svh */
// cpr_consts.svh: offsets, field positions, reset values and counts
// of the codec program register block.
// assumes: included by bare name from every design file that needs it.
`ifndef CPR_CONSTS_SVH
`define CPR_CONSTS_SVH

// register address codes held in instruction byte 1 bits 6:3
`define CPR_ADDR_CTRL 4'h0
`define CPR_ADDR_LDATA 4'h1
`define CPR_ADDR_LDIR 4'h2

// instruction byte 1 field positions
`define CPR_B1_POWER 7
`define CPR_B1_ADDR_HI 6
`define CPR_B1_ADDR_LO 3
`define CPR_B1_READ 2
`define CPR_B1_TWO_BYTE 1

// values held after power-on initialization
`define CPR_CTRL_RESET 8'h89
`define CPR_LDIR_RESET 8'h00
`define CPR_LDATA_RESET 8'h00
`define CPR_SLEEP_RESET 1'b1

// last bit index of a control or pcm byte
`define CPR_BIT_LAST 3'h7
// pcm bits per time slot
`define CPR_SLOT_BITS 4'h8
// transmit frame syncs to wait after power-up
`define CPR_TX_WAKE_FRAMES 2'h2
// even-bit inversion mask for a-law
`define CPR_EVEN_INV_MASK 8'h55
// first latch bit of direction and data bytes (bit 7, descending)
`define CPR_LATCH_TOP 7

`endif

/* File: cpr_host.sv */
// cpr_host.sv: host model driving the serial control port.
// assumes: the block samples control clock levels on ref_clk.
module cpr_host (
  // clock
  input wire logic ref_clk,
  // serial control port
  output logic cs_n,
  output logic control_clock,
  output logic control_in,
  input wire logic control_out,
  input wire logic control_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // port idles deselected with the clock low
  initial begin
    cs_n = 1'b1;
    control_clock = 1'b0;
    control_in = 1'b0;
  end

  // hold every level two ref_clk cycles
  task automatic hold2();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : hold2

  // shift nbits of a byte msb first, capturing read-back on each fall
  task automatic shift(input logic [7:0] b, input int nbits,
                       output logic [7:0] rd);
    rd = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      control_in = b[i];
      control_clock = 1'b1;
      hold2();
      control_clock = 1'b0;
      rd[i] = control_out_oe ? control_out : 1'bx;
      hold2();
    end
  endtask : shift

  // byte 1, then n2 bits of byte 2 (0 single byte, below 8 aborts)
  task automatic instr(input logic [7:0] b1, input logic [7:0] b2,
                       input int n2, output logic [7:0] rd);
    logic [7:0] r1;
    cs_n = 1'b0;
    hold2();
    shift((n2 == 0) ? (b1 & 8'hFD) : b1, 8, r1);
    rd = 8'h00;
    if (n2 > 0) begin
      shift(b2, n2, rd);
    end
    cs_n = 1'b1;
    control_in = ~control_in; // released line shows no stale level
    hold2();
  endtask : instr
endmodule : cpr_host

/* File: cpr_pcm_shift.sv */
// cpr_pcm_shift.sv: pcm transmit and receive byte shifters.
// assumes: bit clock edges arrive as one-cycle pulses of ref_clk and
// slot starts coincide with a bit clock rising pulse.
`include "cpr_consts.svh"
module cpr_pcm_shift (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bit clock edge pulses and slot starts
  input wire logic bclk_rise,
  input wire logic bclk_fall,
  input wire logic tx_start,
  input wire logic rx_start,
  // code selection
  input wire logic even_invert,
  input wire logic digital_loop,
  // data
  input wire logic [7:0] enc_code,
  input wire logic pcm_rx_in,
  output logic pcm_tx_out,
  output logic tx_busy,
  output logic [7:0] dec_code
);
  import cpr_pkg::*;

  logic [7:0] tx_sr;
  logic [3:0] tx_cnt;
  logic [7:0] rx_sr;
  logic [3:0] rx_cnt;
  logic [7:0] rx_reg;
  logic [7:0] enc_sent;
  logic [7:0] load_code;
  logic [7:0] inv_mask;
  logic rx_last;

  // a-law inversion flips the even bits; loopback returns the raw byte
  assign inv_mask = even_invert ? `CPR_EVEN_INV_MASK : 8'h00;
  assign enc_sent = enc_code ^ inv_mask;
  assign load_code = digital_loop ? rx_reg : enc_sent;
  assign tx_busy = (tx_cnt != 4'h0);
  assign pcm_tx_out = tx_sr[7];
  assign rx_last = bclk_fall && (rx_cnt == 4'h1);

  // transmit: load at slot start, shift msb first on rising edges
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_sr <= 8'h00;
      tx_cnt <= 4'h0;
    end else if (tx_start) begin
      tx_sr <= load_code;
      tx_cnt <= `CPR_SLOT_BITS;
    end else if (bclk_rise && tx_busy) begin
      tx_sr <= {tx_sr[6:0], 1'b0};
      tx_cnt <= tx_cnt - 4'h1;
    end
  end

  // receive: msb first on falling edges, whole byte kept at the end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_sr <= 8'h00;
      rx_cnt <= 4'h0;
      rx_reg <= 8'h00;
    end else begin
      if (rx_start) begin
        rx_cnt <= `CPR_SLOT_BITS;
      end else if (bclk_fall && rx_cnt != 4'h0) begin
        rx_sr <= {rx_sr[6:0], pcm_rx_in};
        rx_cnt <= rx_cnt - 4'h1;
      end
      if (rx_last && !rx_start) begin
        rx_reg <= {rx_sr[6:0], pcm_rx_in};
      end
    end
  end

  // decoder sees the code with the inversion undone
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dec_code <= 8'h00;
    end else begin
      dec_code <= rx_reg ^ inv_mask;
    end
  end

  // assertions run on the reference clock and stand down in reset
  default clocking shift_cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_tx_msb_first: assert property (
    tx_start |=> pcm_tx_out == $past(load_code[7]))
    else $error("pcm byte not sent msb first");

  a_alaw_invert: assert property (
    tx_start && even_invert && !digital_loop
      |=> tx_sr == ($past(enc_code) ^ 8'h55))
    else $error("even bits not inverted");

  a_loop_rx_byte: assert property (
    tx_start && digital_loop |=> tx_sr == $past(rx_reg))
    else $error("loopback byte wrong");

endmodule : cpr_pcm_shift

/* File: cpr_pkg.sv */
// cpr_pkg.sv: types shared by the codec program register block.
// assumes: nothing beyond a SystemVerilog compiler.
package cpr_pkg;

  // control register byte 2, msb first
  typedef struct packed {
    logic clk_div_hi;
    logic clk_div_lo;
    logic law_sel;
    logic inversion_off;
    logic timing_sel;
    logic digital_loop_sel;
    logic analog_loop_sel;
    logic amp_off_in_sleep;
  } cpr_ctrl_t;

  // control port byte position
  typedef enum logic [1:0] {
    CPR_ST_BYTE1 = 2'b01,
    CPR_ST_BYTE2 = 2'b10
  } cpr_port_state_t;

endpackage : cpr_pkg

/* File: test_codec_program_registers.sv */
// test_codec_program_registers.sv: self-checking bench of the codec
// program registers, driving the control port and pcm frames.
// assumes: cpr_pkg and cpr_host are compiled first.
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module test_codec_program_registers;
  timeunit 1ns;
  timeprecision 100ps;
  import cpr_pkg::*;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic bclk = 1'b0;
  logic tx_frame_sync = 1'b0;
  logic rx_frame_sync = 1'b0;
  logic pcm_rx_in = 1'b0;
  logic [7:0] enc_code = 8'hB4;
  logic [3:0] latch_pin_in = 4'h3;
  wire cs_n, control_clock, control_in, control_out, control_out_oe;
  wire pcm_tx_out, pcm_tx_oe, sleep_state, amp_enable;
  wire analog_tx_from_rx, digital_loop_on;
  wire [7:0] dec_code;
  wire [3:0] latch_pin_out, latch_pin_oe;
  cpr_ctrl_t ctrl_fields;
  int n_mismatch = 0;
  int compares = 0;
  logic [7:0] rd, txb;
  logic seen;
  logic [7:0] vals [4] = '{8'h00, 8'h55, 8'hB3, 8'hEE};

  // 50 MHz reference clock
  always #10 ref_clk = ~ref_clk;

  cpr_codec_regs i_cpr_codec_regs (
    .ref_clk(ref_clk), .rst(rst), .control_clock(control_clock),
    .control_in(control_in), .cs_n(cs_n), .control_out(control_out),
    .control_out_oe(control_out_oe), .bclk(bclk),
    .tx_frame_sync(tx_frame_sync), .rx_frame_sync(rx_frame_sync),
    .pcm_rx_in(pcm_rx_in), .enc_code(enc_code),
    .pcm_tx_out(pcm_tx_out), .pcm_tx_oe(pcm_tx_oe),
    .dec_code(dec_code), .latch_pin_in(latch_pin_in),
    .latch_pin_out(latch_pin_out), .latch_pin_oe(latch_pin_oe),
    .ctrl_fields(ctrl_fields), .sleep_state(sleep_state),
    .amp_enable(amp_enable), .analog_tx_from_rx(analog_tx_from_rx),
    .digital_loop_on(digital_loop_on)
  );

  cpr_host i_cpr_host (
    .ref_clk(ref_clk), .cs_n(cs_n), .control_clock(control_clock),
    .control_in(control_in), .control_out(control_out),
    .control_out_oe(control_out_oe)
  );

  // print the verdict and stop
  task automatic give_verdict();
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // step to just after the next rising edge
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick

  // one frame of 12 bit clocks, slot in bits dly to dly + 7
  task automatic frame(input logic [7:0] rxb, input int dly);
    seen = 1'b0;
    for (int k = 0; k < 12; k++) begin
      tick();
      bclk = 1'b1; // bit clock made from ref_clk, synchronous
      tx_frame_sync = (k == 0);
      rx_frame_sync = (k == 0);
      pcm_rx_in = (k >= dly && k < dly + 8) ? rxb[7 + dly - k] : k[0];
      tick();
      seen = seen | pcm_tx_oe;
      tick();
      bclk = 1'b0;
      tick();
      seen = seen | pcm_tx_oe;
      if (k >= dly && k < dly + 8) begin
        txb[7 + dly - k] = pcm_tx_out;
      end
    end
    repeat (4) tick();
  endtask : frame

  // hang guard well beyond the expected run
  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    tick();
    `CHK(ctrl_fields, 8'h89);
    `CHK(sleep_state, 1'b1);
    `CHK(amp_enable, 1'b0);
    `CHK(latch_pin_oe, 4'h0);
    `CHK(pcm_tx_oe, 1'b0);
    // every divider, law, timing, loop and amplifier code, powered down
    foreach (vals[j]) begin
      i_cpr_host.instr(8'h82, vals[j], 8, rd);
      i_cpr_host.instr(8'h86, 8'h00, 8, rd);
      `CHK(rd, vals[j]);
      `CHK(ctrl_fields, vals[j]);
      `CHK(analog_tx_from_rx, vals[j][2:1] == 2'b01);
      `CHK(digital_loop_on, vals[j][2]);
      `CHK(amp_enable, ~vals[j][0]);
    end
    // chip select rising mid byte 2 leaves the register alone
    i_cpr_host.instr(8'h82, 8'h12, 4, rd);
    `CHK(ctrl_fields, 8'hEE);
    i_cpr_host.instr(8'h86, 8'h00, 8, rd);
    `CHK(rd, 8'hEE);
    // single byte power commands
    i_cpr_host.instr(8'h00, 8'h00, 0, rd);
    `CHK(sleep_state, 1'b0);
    `CHK(amp_enable, 1'b1);
    i_cpr_host.instr(8'h80, 8'h00, 0, rd);
    `CHK(sleep_state, 1'b1);
    // latch data first, then direction; pins 2 and 3 outputs
    i_cpr_host.instr(8'h8A, 8'hAC, 8, rd);
    i_cpr_host.instr(8'h92, 8'h3C, 8, rd);
    `CHK(latch_pin_oe, 4'hC);
    `CHK(latch_pin_out, 4'h5);
    i_cpr_host.instr(8'h8E, 8'h00, 8, rd);
    `CHK(rd, 8'hEC);
    latch_pin_in = 4'hE;
    i_cpr_host.instr(8'h8E, 8'h00, 8, rd);
    `CHK(rd, 8'h6C);
    i_cpr_host.instr(8'h96, 8'h00, 8, rd);
    `CHK(rd, 8'h3C);
    i_cpr_host.instr(8'hFE, 8'h00, 8, rd);
    `CHK(rd, 8'h00);
    // power up with default control: output held off until second sync
    i_cpr_host.instr(8'h02, 8'h89, 8, rd);
    `CHK(sleep_state, 1'b0);
    frame(8'h5A, 0);
    `CHK(seen, 1'b0);
    `CHK(dec_code, 8'h5A);
    frame(8'h5A, 0);
    frame(8'h5A, 0);
    `CHK(seen, 1'b1);
    `CHK(txb, 8'hB4);
    // a-law with even-bit inversion both ways
    i_cpr_host.instr(8'h02, 8'hA9, 8, rd);
    frame(8'h3C, 0);
    `CHK(txb, 8'hE1);
    `CHK(dec_code, 8'h69);
    // delayed timing: slot opens one bit clock after the sync edge
    i_cpr_host.instr(8'h02, 8'h81, 8, rd);
    frame(8'h96, 1);
    `CHK(txb, 8'hB4);
    `CHK(dec_code, 8'h96);
    // digital loop returns the raw received byte
    i_cpr_host.instr(8'h02, 8'h8D, 8, rd);
    frame(8'hC3, 0);
    frame(8'h00, 0);
    `CHK(txb, 8'hC3);
    // a second reset restores every power-on value
    rst = 1'b1;
    repeat (2) tick();
    rst = 1'b0;
    tick();
    `CHK(ctrl_fields, 8'h89);
    `CHK(sleep_state, 1'b1);
    `CHK(latch_pin_oe, 4'h0);
    `CHK(digital_loop_on, 1'b0);
    give_verdict();
  end
endmodule : test_codec_program_registers
